// *** src/fault_status_pkg.sv ***
// Package for the fault status recorder: offsets, bit positions, event carrier
package fault_status_pkg;

  // Register word offsets (byte addresses on the slave port)
  localparam logic [3:0] status_offset   = 4'h0;
  localparam logic [3:0] ctrl_offset     = 4'h4;
  localparam logic [3:0] mem_addr_offset = 4'h8;
  localparam logic [3:0] bus_addr_offset = 4'hC;

  // Memory fault byte, bits 7..0
  localparam int unsigned instr_access_violation_bit = 0;
  localparam int unsigned data_access_violation_bit  = 1;
  localparam int unsigned mem_unstack_fault_bit      = 3;
  localparam int unsigned mem_stack_fault_bit        = 4;
  localparam int unsigned mem_lazy_fp_fault_bit      = 5;
  localparam int unsigned mem_fault_addr_valid_bit   = 7;

  // Bus fault byte, bits 15..8
  localparam int unsigned instr_bus_error_bit        = 8;
  localparam int unsigned precise_bus_error_bit      = 9;
  localparam int unsigned imprecise_bus_error_bit    = 10;
  localparam int unsigned bus_unstack_fault_bit      = 11;
  localparam int unsigned bus_stack_fault_bit        = 12;
  localparam int unsigned bus_lazy_fp_fault_bit      = 13;
  localparam int unsigned bus_fault_addr_valid_bit   = 15;

  // Usage fault half, bits 31..16
  localparam int unsigned undefined_instruction_bit  = 16;
  localparam int unsigned invalid_state_bit          = 17;
  localparam int unsigned invalid_pc_load_bit        = 18;
  localparam int unsigned no_coprocessor_bit         = 19;
  localparam int unsigned misaligned_access_bit      = 24;

  // Control register bit
  localparam int unsigned misaligned_trap_enable_bit = 3;

  // Values after reset
  localparam logic [31:0] status_reset = 32'h0000_0000;
  localparam logic [31:0] addr_reset   = 32'h0000_0000;
  localparam logic        trap_reset   = 1'b0;

  // Bits that exist in the status word, and unused bit 20
  localparam logic [31:0] status_impl_mask = 32'h011F_BFBB;

  // Fault events from the pipeline and stacking engine, each a one-cycle pulse
  typedef struct packed {
    logic        fetch_never_exec;
    logic        fetch_issue_bus_err;
    logic        data_access_violation;
    logic        mem_unstack;
    logic        mem_stack;
    logic        mem_lazy_fp;
    logic        precise_bus_err;
    logic        imprecise_bus_err;
    logic        bus_unstack;
    logic        bus_stack;
    logic        bus_lazy_fp;
    logic        undefined_instr;
    logic        invalid_state;
    logic        invalid_pc_load;
    logic        coprocessor_access;
    logic        unaligned_access;
    logic        multi_or_double;
    logic [31:0] fault_addr;
  } fault_event_s;

  // What the pipeline must do with the fault
  typedef struct packed {
    logic stack_fault_pc;
    logic keep_return_stack;
    logic adjust_sp;
    logic take_usage;
    logic take_mem;
    logic take_bus;
    logic bus_pending;
  } fault_action_s;

endpackage

// *** src/fault_status_recorder.sv ***
// Fault status recorder: sticky fault flags, address capture, Avalon-MM slave
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.

`timescale 1ns/1ns

module fault_status_recorder (
  // Clock and reset
  input  wire logic                             core_clk,
  input  wire logic                             srst,
  // Avalon-MM slave
  input  wire logic [3:0]                       avs_address,
  input  wire logic                             avs_read,
  input  wire logic                             avs_write,
  input  wire logic [31:0]                      avs_writedata,
  input  wire logic [3:0]                       avs_byteenable,
  output logic      [31:0]                      avs_readdata,
  output logic                                  avs_waitrequest,
  output logic      [1:0]                       avs_response,
  // Fault events from the pipeline
  input  wire fault_status_pkg::fault_event_s   fault_event,
  input  wire logic                             bus_prio_blocked,
  // Actions back to the pipeline
  output fault_status_pkg::fault_action_s       fault_action,
  // Fault address and status outputs
  output logic      [31:0]                      mem_fault_address_reg,
  output logic      [31:0]                      bus_fault_address_reg,
  output logic      [31:0]                      configurable_fault_status
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        ack_reg;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] be_mask;
  logic [31:0] w1c_mask;
  logic        misaligned_trap_enable;
  logic [31:0] set_mask;
  logic        mem_addr_load;
  logic        bus_addr_load;
  logic        bus_fault_pending_reg;
  logic        bus_taken;

  assign wr_hit = avs_write && ack_reg;
  assign rd_hit = avs_read && !ack_reg;

  // Word, halfword or byte lanes
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  assign w1c_mask = (wr_hit && avs_address == fault_status_pkg::status_offset) ?
                    (avs_writedata & be_mask & fault_status_pkg::status_impl_mask) :
                    32'h0000_0000;

  // One wait cycle, then acknowledge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else if (rd_hit) begin
      avs_response <= 2'h0;
      case (avs_address)
        fault_status_pkg::status_offset: begin
          avs_readdata <= configurable_fault_status;
        end
        fault_status_pkg::ctrl_offset: begin
          avs_readdata <= 32'(misaligned_trap_enable)
                          << fault_status_pkg::misaligned_trap_enable_bit;
        end
        fault_status_pkg::mem_addr_offset: begin
          avs_readdata <= mem_fault_address_reg;
        end
        fault_status_pkg::bus_addr_offset: begin
          avs_readdata <= bus_fault_address_reg;
        end
        default: begin
          avs_readdata <= 32'h0000_0000;
          avs_response <= 2'h2;
        end
      endcase
    end else if (avs_write && !ack_reg) begin
      avs_response <= (avs_address == fault_status_pkg::status_offset ||
                       avs_address == fault_status_pkg::ctrl_offset ||
                       avs_address == fault_status_pkg::mem_addr_offset ||
                       avs_address == fault_status_pkg::bus_addr_offset) ? 2'h0 : 2'h2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge core_clk) begin
    if (srst) begin
      misaligned_trap_enable <= fault_status_pkg::trap_reset;
    end else if (wr_hit && avs_address == fault_status_pkg::ctrl_offset &&
                 avs_byteenable[0]) begin
      misaligned_trap_enable <= avs_writedata[fault_status_pkg::misaligned_trap_enable_bit];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event to flag mapping

  always_comb begin
    set_mask = 32'h0000_0000;
    set_mask[fault_status_pkg::instr_access_violation_bit] =
      fault_event.fetch_never_exec;
    set_mask[fault_status_pkg::data_access_violation_bit] =
      fault_event.data_access_violation;
    set_mask[fault_status_pkg::mem_unstack_fault_bit] = fault_event.mem_unstack;
    set_mask[fault_status_pkg::mem_stack_fault_bit] = fault_event.mem_stack;
    set_mask[fault_status_pkg::mem_lazy_fp_fault_bit] = fault_event.mem_lazy_fp;
    set_mask[fault_status_pkg::mem_fault_addr_valid_bit] = mem_addr_load;
    set_mask[fault_status_pkg::instr_bus_error_bit] =
      fault_event.fetch_issue_bus_err;
    set_mask[fault_status_pkg::precise_bus_error_bit] =
      fault_event.precise_bus_err;
    set_mask[fault_status_pkg::imprecise_bus_error_bit] =
      fault_event.imprecise_bus_err;
    set_mask[fault_status_pkg::bus_unstack_fault_bit] = fault_event.bus_unstack;
    set_mask[fault_status_pkg::bus_stack_fault_bit] = fault_event.bus_stack;
    set_mask[fault_status_pkg::bus_lazy_fp_fault_bit] = fault_event.bus_lazy_fp;
    set_mask[fault_status_pkg::bus_fault_addr_valid_bit] = bus_addr_load;
    set_mask[fault_status_pkg::undefined_instruction_bit] =
      fault_event.undefined_instr;
    set_mask[fault_status_pkg::invalid_state_bit] =
      fault_event.invalid_state && !fault_event.undefined_instr;
    set_mask[fault_status_pkg::invalid_pc_load_bit] =
      fault_event.invalid_pc_load;
    set_mask[fault_status_pkg::no_coprocessor_bit] =
      fault_event.coprocessor_access;
    set_mask[fault_status_pkg::misaligned_access_bit] = fault_event.unaligned_access &&
      (misaligned_trap_enable || fault_event.multi_or_double);
  end

  // Only data violations and precise errors carry a known address
  assign mem_addr_load = fault_event.data_access_violation;
  assign bus_addr_load = fault_event.precise_bus_err;

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky status word

  // Unimplemented bits read as zero
  assign configurable_fault_status[2]     = 1'b0;
  assign configurable_fault_status[6]     = 1'b0;
  assign configurable_fault_status[14]    = 1'b0;
  assign configurable_fault_status[23:20] = 4'h0;
  assign configurable_fault_status[31:25] = 7'h00;

  // Memory fault byte; each cell lets set win over clear
  sticky_flag_cell u_instr_access_violation (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::instr_access_violation_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::instr_access_violation_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::instr_access_violation_bit]));
  sticky_flag_cell u_data_access_violation (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::data_access_violation_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::data_access_violation_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::data_access_violation_bit]));
  sticky_flag_cell u_mem_unstack_fault (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::mem_unstack_fault_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::mem_unstack_fault_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::mem_unstack_fault_bit]));
  sticky_flag_cell u_mem_stack_fault (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::mem_stack_fault_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::mem_stack_fault_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::mem_stack_fault_bit]));
  sticky_flag_cell u_mem_lazy_fp_fault (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::mem_lazy_fp_fault_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::mem_lazy_fp_fault_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::mem_lazy_fp_fault_bit]));
  sticky_flag_cell u_mem_fault_addr_valid (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::mem_fault_addr_valid_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::mem_fault_addr_valid_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::mem_fault_addr_valid_bit]));

  // Bus fault byte; imprecise flag is only cleared by software
  sticky_flag_cell u_instr_bus_error (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::instr_bus_error_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::instr_bus_error_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::instr_bus_error_bit]));
  sticky_flag_cell u_precise_bus_error (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::precise_bus_error_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::precise_bus_error_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::precise_bus_error_bit]));
  sticky_flag_cell u_imprecise_bus_error (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::imprecise_bus_error_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::imprecise_bus_error_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::imprecise_bus_error_bit]));
  sticky_flag_cell u_bus_unstack_fault (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::bus_unstack_fault_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::bus_unstack_fault_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::bus_unstack_fault_bit]));
  sticky_flag_cell u_bus_stack_fault (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::bus_stack_fault_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::bus_stack_fault_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::bus_stack_fault_bit]));
  sticky_flag_cell u_bus_lazy_fp_fault (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::bus_lazy_fp_fault_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::bus_lazy_fp_fault_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::bus_lazy_fp_fault_bit]));
  // A later data access violation invalidates the bus address
  sticky_flag_cell u_bus_fault_addr_valid (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::bus_fault_addr_valid_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::bus_fault_addr_valid_bit] || mem_addr_load),
    .flag_reg (configurable_fault_status[fault_status_pkg::bus_fault_addr_valid_bit]));

  // Usage fault half
  sticky_flag_cell u_undefined_instruction (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::undefined_instruction_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::undefined_instruction_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::undefined_instruction_bit]));
  sticky_flag_cell u_invalid_state (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::invalid_state_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::invalid_state_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::invalid_state_bit]));
  sticky_flag_cell u_invalid_pc_load (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::invalid_pc_load_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::invalid_pc_load_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::invalid_pc_load_bit]));
  sticky_flag_cell u_no_coprocessor (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::no_coprocessor_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::no_coprocessor_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::no_coprocessor_bit]));
  sticky_flag_cell u_misaligned_access (.core_clk (core_clk), .srst (srst),
    .set_in   (set_mask[fault_status_pkg::misaligned_access_bit]),
    .clr_in   (w1c_mask[fault_status_pkg::misaligned_access_bit]),
    .flag_reg (configurable_fault_status[fault_status_pkg::misaligned_access_bit]));

  ////////////////////////////////////////////////////////////////////////////////
  // Fault address registers

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_fault_address_reg <= fault_status_pkg::addr_reset;
    end else if (mem_addr_load) begin
      mem_fault_address_reg <= fault_event.fault_addr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_fault_address_reg <= fault_status_pkg::addr_reset;
    end else if (bus_addr_load) begin
      bus_fault_address_reg <= fault_event.fault_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Imprecise bus fault pending

  assign bus_taken = !bus_prio_blocked;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_fault_pending_reg <= 1'b0;
    end else if (fault_event.imprecise_bus_err && bus_prio_blocked) begin
      bus_fault_pending_reg <= 1'b1;
    end else if (bus_taken) begin
      bus_fault_pending_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Actions back to the pipeline

  always_comb begin
    fault_action.stack_fault_pc = fault_event.fetch_never_exec ||
                                  fault_event.data_access_violation ||
                                  fault_event.precise_bus_err ||
                                  fault_event.undefined_instr ||
                                  fault_event.invalid_state ||
                                  fault_event.invalid_pc_load;
    fault_action.keep_return_stack = fault_event.mem_unstack ||
                                     fault_event.bus_unstack;
    fault_action.adjust_sp = fault_event.mem_stack || fault_event.bus_stack;
    fault_action.take_mem = |set_mask[6:0];
    fault_action.take_bus = (|set_mask[14:8] & ~set_mask[10]) ||
                            (fault_event.imprecise_bus_err && bus_taken) ||
                            (bus_fault_pending_reg && bus_taken);
    fault_action.take_usage = |set_mask[31:16];
    fault_action.bus_pending = bus_fault_pending_reg;
  end

endmodule

////////////////////////////////////////////////////////////////////////////////
// One sticky flag: set wins over a same-cycle write-one clear

module sticky_flag_cell (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // Set and clear strobes
  input  wire logic set_in,
  input  wire logic clr_in,
  // Stored flag
  output logic      flag_reg
);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      flag_reg <= 1'b0;
    end else if (set_in) begin
      flag_reg <= 1'b1;
    end else if (clr_in) begin
      flag_reg <= 1'b0;
    end
  end

endmodule

// *** verif/fault_status_recorder_sva.sv ***
// Checker: port-level assertions for the fault status recorder
`timescale 1ns/1ns

module fault_status_recorder_sva (
  // Clock and reset
  input wire logic                            core_clk,
  input wire logic                            srst,
  // Register bus
  input wire logic [3:0]                      avs_address,
  input wire logic                            avs_read,
  input wire logic                            avs_write,
  input wire logic                            avs_waitrequest,
  // Fault side
  input wire fault_status_pkg::fault_event_s  fault_event,
  input wire logic                            bus_prio_blocked,
  input wire fault_status_pkg::fault_action_s fault_action,
  input wire logic [31:0]                     mem_fault_address_reg,
  input wire logic [31:0]                     bus_fault_address_reg,
  input wire logic [31:0]                     configurable_fault_status
);
  wire fault_status_pkg::fault_event_s ev = fault_event;
  wire logic [31:0]                    st = configurable_fault_status;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // One wait cycle, then the answer
  sequence s_wait_go;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  AST_WAIT:
    assert property ($rose(avs_read || avs_write) |-> s_wait_go) else $error("late bus answer");
  AST_IACC:
    assert property (ev.fetch_never_exec && !ev.data_access_violation
      |=> st[0] && $stable(mem_fault_address_reg)) else $error("fetch fault wrong");
  AST_DACC:
    assert property (ev.data_access_violation && !ev.precise_bus_err |=> st[1] && st[7]
      && !st[15] && mem_fault_address_reg == $past(ev.fault_addr)) else $error("data fault wrong");
  AST_PREC:
    assert property (ev.precise_bus_err |=> st[9] && st[15] && ($past(ev.imprecise_bus_err)
      -> st[10]) && bus_fault_address_reg == $past(ev.fault_addr)) else $error("precise wrong");
  AST_NOADDR:
    assert property ((ev.fetch_issue_bus_err || ev.imprecise_bus_err || ev.bus_unstack
      || ev.bus_stack) && !ev.precise_bus_err |=> $stable(bus_fault_address_reg))
      else $error("bus address written");
  AST_UNSTK:
    assert property ((ev.mem_unstack || ev.bus_unstack) && !ev.mem_stack && !ev.bus_stack
      |-> fault_action.keep_return_stack && !fault_action.adjust_sp) else $error("unstack wrong");
  AST_STK:
    assert property (ev.mem_stack || ev.bus_stack |-> fault_action.adjust_sp)
      else $error("stack pointer not adjusted");
  AST_PEND:
    assert property (ev.imprecise_bus_err && bus_prio_blocked |=> fault_action.bus_pending)
      else $error("bus fault not pending");
  AST_STICKY:
    assert property (|($past(st) & ~st & 32'hFFFF_7FFF) |-> $past(avs_write)
      && $past(avs_address) == fault_status_pkg::status_offset) else $error("flag dropped");
endmodule

bind fault_status_recorder fault_status_recorder_sva u_sva (.core_clk, .srst, .avs_address,
  .avs_read, .avs_write, .avs_waitrequest, .fault_event, .bus_prio_blocked, .fault_action,
  .mem_fault_address_reg, .bus_fault_address_reg, .configurable_fault_status);

// *** verif/fault_source_model.sv ***
// Pipeline model: reports one fault event at a time as a one-cycle pulse
`timescale 1ns/1ns

module fault_source_model (
  // Clock
  input  wire logic                     core_clk,
  // Fault reports
  output fault_status_pkg::fault_event_s fault_event,
  output logic                           bus_prio_blocked
);
  initial begin
    fault_event      = '0;
    bus_prio_blocked = 1'b0;
  end

  // Priority level holds until the next report; the address wanders once released
  task automatic fire(input fault_status_pkg::fault_event_s ev, input logic blocked);
    @(posedge core_clk);
    fault_event      <= ev; // Bus errors reported at issue only
    bus_prio_blocked <= blocked;
    @(posedge core_clk);
    fault_event      <= {17'h0_0000, ~ev.fault_addr};
  endtask
endmodule

// *** verif/testbench.sv ***
// Testbench: register bus tasks and fault event sequences
`timescale 1ns/1ns

module testbench;
  logic                            core_clk = 1'b0;
  logic                            srst = 1'b1;
  logic                            avs_read = 1'b0;
  logic                            avs_write = 1'b0;
  logic [3:0]                      avs_address = 4'h0;
  logic [3:0]                      avs_byteenable = 4'h0;
  logic [31:0]                     avs_writedata = 32'h0000_0000;
  logic [31:0]                     avs_readdata, mem_fault_address_reg, bus_fault_address_reg;
  logic [31:0]                     configurable_fault_status, rd, em, eb, a;
  logic [1:0]                      avs_response, rr;
  logic                            avs_waitrequest, bus_prio_blocked;
  fault_status_pkg::fault_event_s  fault_event;
  fault_status_pkg::fault_action_s fault_action;
  logic [16:0]                     fl [19];
  logic [31:0]                     ex [19];
  int                              err_total = 0;
  int                              samples_checked = 0;

  always #25 core_clk = ~core_clk;

  fault_source_model src (.core_clk, .fault_event, .bus_prio_blocked);
  fault_status_recorder dut (.core_clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .fault_event, .bus_prio_blocked, .fault_action, .mem_fault_address_reg,
    .bus_fault_address_reg, .configurable_fault_status);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("TB: checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One transfer, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [3:0] ad, input logic [31:0] d,
                      input logic [3:0] be);
    @(posedge core_clk);
    avs_address    <= ad;
    avs_write      <= w;
    avs_read       <= !w;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do @(negedge core_clk); while (avs_waitrequest !== 1'b0);
    @(posedge core_clk);
    rd = avs_readdata;
    rr = avs_response;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [3:0] ad, input logic [31:0] e);
    xfer(1'b0, ad, 32'h0000_0000, 4'hF);
    chk(nm, e, rd);
    chk("response", (ad == 4'h1) ? 32'h0000_0002 : 32'h0000_0000, {30'h0000_0000, rr});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rdc("status", fault_status_pkg::status_offset, fault_status_pkg::status_reset);
    rdc("ctrl", fault_status_pkg::ctrl_offset, 32'h0000_0000);
    rdc("mem addr", fault_status_pkg::mem_addr_offset, fault_status_pkg::addr_reset);
    rdc("bus addr", fault_status_pkg::bus_addr_offset, fault_status_pkg::addr_reset);
    rdc("unmapped", 4'h1, 32'h0000_0000);
    $display("test reset done");
    fl = '{17'h10000, 17'h08000, 17'h04000, 17'h02000, 17'h01000, 17'h00800, 17'h00400,
           17'h00200, 17'h00100, 17'h00080, 17'h00040, 17'h00020, 17'h00010, 17'h00008,
           17'h00004, 17'h00003, 17'h00002, 17'h00030, 17'h00600};
    ex = '{32'h1, 32'h100, 32'h82, 32'h8, 32'h10, 32'h20, 32'h8200,
           32'h400, 32'h800, 32'h1000, 32'h2000, 32'h10000, 32'h20000,
           32'h40000, 32'h80000, 32'h1000000, 32'h0, 32'h10000, 32'h8600};
    em = 32'h0000_0000;
    eb = 32'h0000_0000;
    for (int i = 0; i < 19; i++) begin
      a = {24'hA5A500, 8'(i)};
      xfer(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
      src.fire({fl[i], a}, 1'b0);
      if (fl[i][14])
        em = a;
      if (fl[i][10])
        eb = a;
      rdc("status", 4'h0, ex[i]);
      chk("mem addr", em, mem_fault_address_reg);
      chk("bus addr", eb, bus_fault_address_reg);
    end
    xfer(1'b1, fault_status_pkg::ctrl_offset, 32'h0000_0008, 4'hF);
    rdc("ctrl", fault_status_pkg::ctrl_offset, 32'h0000_0008);
    xfer(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
    src.fire({17'h00002, 32'h0000_0003}, 1'b0);
    rdc("status", 4'h0, 32'h0100_0000);
    $display("test fault table done");
    xfer(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
    src.fire({17'h00600, 32'h0000_1000}, 1'b1);
    rdc("status", 4'h0, 32'h0000_8600);
    xfer(1'b1, 4'h0, 32'h0000_8000, 4'h2);
    rdc("status", 4'h0, 32'h0000_0600);
    src.fire({17'h04000, 32'h0000_2000}, 1'b0);
    xfer(1'b1, 4'h0, 32'hFFFF_FF80, 4'h1);
    rdc("status", 4'h0, 32'h0000_0602);
    src.fire({17'h00020, 32'h0000_3000}, 1'b0);
    xfer(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hC);
    rdc("status", 4'h0, 32'h0000_0602);
    xfer(1'b1, 4'h0, 32'h0000_FF00, 4'h3);
    rdc("status", 4'h0, 32'h0000_0002);
    xfer(1'b1, fault_status_pkg::mem_addr_offset, 32'hFFFF_FFFF, 4'hF);
    rdc("mem addr", fault_status_pkg::mem_addr_offset, 32'h0000_2000);
    rdc("bus addr", fault_status_pkg::bus_addr_offset, 32'h0000_1000);
    $display("test clear lanes done");
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rdc("status", 4'h0, 32'h0000_0000);
    rdc("ctrl", fault_status_pkg::ctrl_offset, 32'h0000_0000);
    $display("test second reset done");
    conclude();
  end

  initial begin
    #(50 * 5000);
    err_total++;
    conclude();
  end
endmodule
